/* File: verilog/brc_pkg.sv */
// Purpose: Shared constants and types of the backup-domain real-time clock core.
// Assumes: One bus clock (hclk); RTC source clocks arrive as slow pins.
// Notes:   Registers are 16 bits wide, one per aligned 32-bit word.
//
// Overview of operation
// - 20-bit prescaler divides selected RTC clock
// - 32-bit counter, loadable, counts time-base ticks
// - Each tick raises second flag and interrupt
// - Counter equals alarm raises alarm flag
// - Counter wrap to zero raises overflow flag
// - Three selectable RTC clock sources
// - 16-bit registers on the bus clock
// - Bus logic system reset, core backup reset
// - Non-core registers cleared by system reset
// - Time, reload, alarm and source select survive system reset
// - Readable copies refresh on each RTC edge
// - Software clears sync flag, waits for set
// - Bus side unaffected by processor sleep
// - Load/counter/alarm writes need configuration mode
// - Writes accepted only while write-done reads 1
// - Commit on leaving configuration, three RTC cycles
// - Second flag before each counter increment; core raises it on the same hclk edge
// - Overflow flag before counter becomes zero; core raises it on the same hclk edge
// - Alarm flag before counter reaches alarm+1; core raises it on the same hclk edge
// - Writes blocked until backup unlock is set
// - Time base is RTC clock over reload+1
// - Write-done reads 0 while commit runs
// - Counter write also reloads prescaler divider
package brc_pkg;

   // ****************************************************************
   // Register map (byte addresses, address bits 7 to 2 decoded).
   // ****************************************************************
   localparam logic [7:0] BRC_CRH_OFF   = 8'h00;  // Interrupt enables.
   localparam logic [7:0] BRC_CRL_OFF   = 8'h04;  // Flags and status.
   localparam logic [7:0] BRC_PRLH_OFF  = 8'h08;  // Reload high, write only.
   localparam logic [7:0] BRC_PRLL_OFF  = 8'h0C;  // Reload low, write only.
   localparam logic [7:0] BRC_DIVH_OFF  = 8'h10;  // Divider high, read only.
   localparam logic [7:0] BRC_DIVL_OFF  = 8'h14;  // Divider low, read only.
   localparam logic [7:0] BRC_CNTH_OFF  = 8'h18;  // Counter high.
   localparam logic [7:0] BRC_CNTL_OFF  = 8'h1C;  // Counter low.
   localparam logic [7:0] BRC_ALRH_OFF  = 8'h20;  // Alarm high.
   localparam logic [7:0] BRC_ALRL_OFF  = 8'h24;  // Alarm low.
   localparam logic [7:0] BRC_SRC_OFF   = 8'h28;  // Clock source select.

   // ****************************************************************
   // Field positions of the flag register.
   // ****************************************************************
   localparam int BRC_SECOND_TICK_FLAG_BIT  = 0;  // Second flag.
   localparam int BRC_ALARM_HIT_FLAG_BIT  = 1;  // Alarm flag.
   localparam int BRC_OWF_BIT   = 2;  // Overflow flag.
   localparam int BRC_RSF_BIT   = 3;  // Registers synced flag.
   localparam int BRC_CNF_BIT   = 4;  // Configuration mode bit.
   localparam int BRC_WRITE_DONE_STATUS_BIT = 5;  // Write done status.

   // ****************************************************************
   // Reset values and timing.
   // ****************************************************************
   localparam logic [19:0] BRC_PRL_RST   = 20'h08000;  // Reload after backup reset.
   localparam logic [19:0] BRC_DIV_RST   = 20'h08000;  // Divider after backup reset.
   localparam logic [1:0]  BRC_COMMIT_LAST = 2'h2;     // Third RTC edge ends a commit.

   // Clock source codes.
   localparam logic [1:0] BRC_SRC_LOCAL = 2'h0;  // Core logic local clock.
   localparam logic [1:0] BRC_SRC_EXT   = 2'h1;  // External low-speed oscillator.
   localparam logic [1:0] BRC_SRC_INT   = 2'h2;  // Internal low-speed oscillator.

   // Pending-write mask positions.
   localparam int BRC_P_PRLH = 0;
   localparam int BRC_P_PRLL = 1;
   localparam int BRC_P_ALRH = 2;
   localparam int BRC_P_ALRL = 3;
   localparam int BRC_P_CNTH = 4;
   localparam int BRC_P_CNTL = 5;

   // ****************************************************************
   // Types.
   // ****************************************************************
   typedef enum logic [1:0] {
      BRC_AH_IDLE   = 2'b00,  // No data phase in progress.
      BRC_AH_WRITE  = 2'b01,  // Write data phase.
      BRC_AH_RDWAIT = 2'b10   // Read wait state, data being fetched.
   } brc_ahb_t;

   typedef enum logic {
      BRC_CM_IDLE = 1'b0,     // No commit, write done reads 1.
      BRC_CM_RUN  = 1'b1      // Commit running.
   } brc_commit_t;

   // Backup-domain core state.
   typedef struct packed {
      logic [1:0]  src_sel;
      logic [19:0] prl;
      logic [31:0] alr;
      logic [31:0] cnt;
      logic [19:0] div;
   } brc_core_t;

   // Bus-side state, cleared by system reset.
   typedef struct packed {
      brc_ahb_t    ah;
      logic [7:0]  addr;
      logic        hreadyout;
      logic [31:0] hrdata;
      logic [2:0]  ie;
      logic        config_mode_bit;
      logic        regs_synced_flag;
      logic        wrap_flag;
      logic        alarm_hit_flag;
      logic        second_tick_flag;
      logic [19:0] sh_prl;
      logic [31:0] sh_alr;
      logic [31:0] sh_cnt;
      logic [5:0]  pend;
      brc_commit_t cm;
      logic [1:0]  edges;
      logic [19:0] rd_div;
      logic [31:0] rd_cnt;
      logic [31:0] rd_alr;
      logic        second_irq;
      logic        alarm_irq;
      logic        wrap_irq;
      logic        alarm_out;
   } brc_bus_t;

   // Source selector state.
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic       last;
      logic       rise;
   } brc_sync_t;

endpackage : brc_pkg

/* File: verilog/brc_src_sync.sv */
// Purpose: Synchronise the three RTC source clocks and flag rising edges.
// Assumes: Sources are much slower than hclk.
// Notes:   Output rise is a one-cycle pulse in the hclk domain.
`timescale 1ns/10ps

module brc_src_sync
   import brc_pkg::*;
(
   // Clock and reset.
   input  wire logic       hclk,
   input  wire logic       bkp_resetn,
   // Source pins and selection.
   input  wire logic       core_logic_local_clock,
   input  wire logic       external_low_speed_osc,
   input  wire logic       internal_low_speed_osc,
   input  wire logic [1:0] src_sel,
   // Edge pulse.
   output logic            rise
);

   brc_sync_t st_q;  // Registered state.
   brc_sync_t st_d;  // Next state.
   logic      sel_lvl;  // Selected, synchronised source level.

   // ****************************************************************
   // Next state.
   // ****************************************************************
   // Only the second stage is read, so the first stage can settle freely.
   always_comb
   begin
      st_d    = st_q;
      st_d.s1 = {internal_low_speed_osc, external_low_speed_osc, core_logic_local_clock};
      st_d.s2 = st_q.s1;
      case (src_sel)
         BRC_SRC_LOCAL: sel_lvl = st_q.s2[0];
         BRC_SRC_EXT:   sel_lvl = st_q.s2[1];
         BRC_SRC_INT:   sel_lvl = st_q.s2[2];
         default:       sel_lvl = 1'b0;  // No source: the core stands still.
      endcase
      st_d.last = sel_lvl;
      st_d.rise = sel_lvl & ~st_q.last;
   end

   // Registers; reset with the backup domain so the core is never disturbed.
   always_ff @(posedge hclk or negedge bkp_resetn)
   begin
      if (!bkp_resetn)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign rise = st_q.rise;

endmodule : brc_src_sync

/* File: verilog/brc_top.sv */
// Purpose: Backup-domain RTC core with an AHB-Lite register slave.
// Assumes: Single word transfers; hsize is not checked.
// Notes:   Reads take one wait state, writes none; response always OKAY.
`timescale 1ns/10ps

module brc_top
   import brc_pkg::*;
(
   // Clock and resets.
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        bkp_resetn,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // RTC clock sources and backup unlock.
   input  wire logic        core_logic_local_clock,
   input  wire logic        external_low_speed_osc,
   input  wire logic        internal_low_speed_osc,
   input  wire logic        backup_write_unlock,
   // Event outputs.
   output logic             second_irq,
   output logic             alarm_irq,
   output logic             wrap_irq,
   output logic             alarm_out
);

   // ****************************************************************
   // Declarations.
   // ****************************************************************
   brc_core_t   core_q;     // Backup-domain state.
   brc_core_t   core_d;     // Next backup-domain state.
   brc_bus_t    bus_q;      // Bus-side state.
   brc_bus_t    bus_d;      // Next bus-side state.
   logic        rtc_rise;   // One-cycle pulse per RTC source edge.
   logic        tick;       // Time base tick.
   logic        commit_go;  // Buffered writes land in the core now.
   logic        sec_ev;     // Second event.
   logic        alarm_ev;   // Alarm event.
   logic        wrap_ev;    // Overflow event.
   logic        accept;     // Address phase taken.
   logic        wr_ok;      // Write data phase allowed to act.
   logic        write_done_status;      // Write done status.
   logic [15:0] wd;         // Write data, low half word.
   logic        unused_ok;  // Bits that are intentionally ignored.

   // Replace one 16-bit half of a 32-bit value.
   function automatic logic [31:0] set_half(input logic [31:0] v, input logic hi,
                                            input logic [15:0] d);
      set_half = hi ? {d, v[15:0]} : {v[31:16], d};
   endfunction : set_half

   // ****************************************************************
   // Source selection and edge detection.
   // ****************************************************************
   brc_src_sync u_src (
      .hclk                   (hclk),
      .bkp_resetn             (bkp_resetn),
      .core_logic_local_clock (core_logic_local_clock),
      .external_low_speed_osc (external_low_speed_osc),
      .internal_low_speed_osc (internal_low_speed_osc),
      .src_sel                (core_q.src_sel),
      .rise                   (rtc_rise)
   );

   // ****************************************************************
   // Events and handshake terms.
   // ****************************************************************
   // divider expiry forms the tick
   assign tick      = rtc_rise && (core_q.div == 20'h00000);
   assign sec_ev    = tick;
   assign wrap_ev   = tick && (core_q.cnt == 32'hFFFFFFFF);
   // alarm when counter goes to alarm+1
   assign alarm_ev  = tick && (core_q.cnt == core_q.alr);
   // commit ends on the third RTC edge
   assign commit_go = (bus_q.cm == BRC_CM_RUN) && rtc_rise && (bus_q.edges == BRC_COMMIT_LAST);
   // write done is low while a commit runs
   assign write_done_status     = (bus_q.cm == BRC_CM_IDLE);
   // the slave never looks at processor sleep state
   assign accept    = hsel && hready && htrans[1];
   assign wr_ok     = (bus_q.ah == BRC_AH_WRITE) && write_done_status && backup_write_unlock;
   assign wd        = hwdata[15:0];
   assign unused_ok = ^{haddr[31:8], hsize, hwdata[31:16]};

   // ****************************************************************
   // Backup-domain core.
   // ****************************************************************
   // Counter, divider, reload and alarm advance only on RTC edges.
   always_comb
   begin
      core_d = core_q;
      if (tick)
      begin
         core_d.div = core_q.prl;
         core_d.cnt = core_q.cnt + 32'h00000001;
      end
      else if (rtc_rise)
      begin
         core_d.div = core_q.div - 20'h00001;
      end
      if (commit_go)
      begin
         if (bus_q.pend[BRC_P_PRLH])
            core_d.prl[19:16] = bus_q.sh_prl[19:16];
         if (bus_q.pend[BRC_P_PRLL])
            core_d.prl[15:0] = bus_q.sh_prl[15:0];
         if (bus_q.pend[BRC_P_ALRH])
            core_d.alr[31:16] = bus_q.sh_alr[31:16];
         if (bus_q.pend[BRC_P_ALRL])
            core_d.alr[15:0] = bus_q.sh_alr[15:0];
         if (bus_q.pend[BRC_P_CNTH])
            core_d.cnt[31:16] = bus_q.sh_cnt[31:16];
         if (bus_q.pend[BRC_P_CNTL])
            core_d.cnt[15:0] = bus_q.sh_cnt[15:0];
         // any buffered write (reload, alarm or counter) restarts the divider
         if (bus_q.pend != 6'h00)
            core_d.div = core_d.prl;
      end
      // Source select lives with the core so a system reset keeps it.
      if (wr_ok && (bus_q.addr == BRC_SRC_OFF))
         core_d.src_sel = wd[1:0];
   end

   // core cleared only by backup reset
   always_ff @(posedge hclk or negedge bkp_resetn)
   begin
      if (!bkp_resetn)
      begin
         core_q         <= '0;
         core_q.prl     <= BRC_PRL_RST;
         core_q.div     <= BRC_DIV_RST;
      end
      else
      begin
         core_q <= core_d;
      end
   end

   // ****************************************************************
   // Bus-side registers and AHB-Lite slave.
   // ****************************************************************
   // Write side effects first, events after, so a set beats a clear.
   always_comb
   begin
      bus_d           = bus_q;
      bus_d.hreadyout = 1'b1;
      if (wr_ok)
      begin
         case (bus_q.addr)
            BRC_CRH_OFF:
               bus_d.ie = wd[2:0];
            BRC_CRL_OFF:
            begin
               // Flags clear on a written zero; a one leaves them alone.
               bus_d.second_tick_flag = bus_q.second_tick_flag & wd[BRC_SECOND_TICK_FLAG_BIT];
               bus_d.alarm_hit_flag = bus_q.alarm_hit_flag & wd[BRC_ALARM_HIT_FLAG_BIT];
               bus_d.wrap_flag  = bus_q.wrap_flag  & wd[BRC_OWF_BIT];
               bus_d.regs_synced_flag  = bus_q.regs_synced_flag  & wd[BRC_RSF_BIT];
               bus_d.config_mode_bit  = wd[BRC_CNF_BIT];
               if (bus_q.config_mode_bit && !wd[BRC_CNF_BIT] && (bus_q.pend != 6'h00))
               begin
                  bus_d.cm    = BRC_CM_RUN;
                  bus_d.edges = 2'h0;
               end
            end
            default:
            begin
               // buffered loads only in configuration mode
               if (bus_q.config_mode_bit)
               begin
                  case (bus_q.addr)
                     BRC_PRLH_OFF:
                     begin
                        bus_d.sh_prl[19:16]    = wd[3:0];
                        bus_d.pend[BRC_P_PRLH] = 1'b1;
                     end
                     BRC_PRLL_OFF:
                     begin
                        bus_d.sh_prl[15:0]     = wd;
                        bus_d.pend[BRC_P_PRLL] = 1'b1;
                     end
                     BRC_ALRH_OFF:
                     begin
                        bus_d.sh_alr           = set_half(bus_q.sh_alr, 1'b1, wd);
                        bus_d.pend[BRC_P_ALRH] = 1'b1;
                     end
                     BRC_ALRL_OFF:
                     begin
                        bus_d.sh_alr           = set_half(bus_q.sh_alr, 1'b0, wd);
                        bus_d.pend[BRC_P_ALRL] = 1'b1;
                     end
                     BRC_CNTH_OFF:
                     begin
                        bus_d.sh_cnt           = set_half(bus_q.sh_cnt, 1'b1, wd);
                        bus_d.pend[BRC_P_CNTH] = 1'b1;
                     end
                     BRC_CNTL_OFF:
                     begin
                        bus_d.sh_cnt           = set_half(bus_q.sh_cnt, 1'b0, wd);
                        bus_d.pend[BRC_P_CNTL] = 1'b1;
                     end
                     default:
                        bus_d.pend = bus_q.pend;  // Unmapped or read-only: ignored.
                  endcase
               end
            end
         endcase
      end

      // Commit progress counts RTC edges.
      if ((bus_q.cm == BRC_CM_RUN) && rtc_rise)
      begin
         if (commit_go)
         begin
            bus_d.cm   = BRC_CM_IDLE;
            bus_d.pend = 6'h00;
         end
         else
         begin
            bus_d.edges = bus_q.edges + 2'h1;
         end
      end

      // readable copies refresh on each RTC edge
      if (rtc_rise)
      begin
         bus_d.rd_div    = core_d.div;
         bus_d.rd_cnt    = core_d.cnt;
         bus_d.rd_alr    = core_d.alr;
         bus_d.regs_synced_flag       = 1'b1;
         // The alarm pin lasts one RTC cycle.
         bus_d.alarm_out = alarm_ev;
      end
      if (sec_ev)
         bus_d.second_tick_flag = 1'b1;
      if (alarm_ev)
         bus_d.alarm_hit_flag = 1'b1;
      if (wrap_ev)
         bus_d.wrap_flag = 1'b1;

      bus_d.second_irq = bus_d.second_tick_flag & bus_d.ie[0];
      bus_d.alarm_irq  = bus_d.alarm_hit_flag & bus_d.ie[1];
      bus_d.wrap_irq   = bus_d.wrap_flag  & bus_d.ie[2];

      // Bus phase tracking; reads fetch in a wait state so a write just
      // before them is already visible.
      case (bus_q.ah)
         BRC_AH_RDWAIT:
         begin
            bus_d.ah = BRC_AH_IDLE;
            case (bus_q.addr)
               BRC_CRH_OFF:  bus_d.hrdata = {29'h0, bus_q.ie};
               BRC_CRL_OFF:  bus_d.hrdata = {26'h0, write_done_status, bus_q.config_mode_bit, bus_q.regs_synced_flag,
                                             bus_q.wrap_flag, bus_q.alarm_hit_flag, bus_q.second_tick_flag};
               BRC_DIVH_OFF: bus_d.hrdata = {28'h0, bus_q.rd_div[19:16]};
               BRC_DIVL_OFF: bus_d.hrdata = {16'h0, bus_q.rd_div[15:0]};
               BRC_CNTH_OFF: bus_d.hrdata = {16'h0, bus_q.rd_cnt[31:16]};
               BRC_CNTL_OFF: bus_d.hrdata = {16'h0, bus_q.rd_cnt[15:0]};
               BRC_ALRH_OFF: bus_d.hrdata = {16'h0, bus_q.rd_alr[31:16]};
               BRC_ALRL_OFF: bus_d.hrdata = {16'h0, bus_q.rd_alr[15:0]};
               BRC_SRC_OFF:  bus_d.hrdata = {30'h0, core_q.src_sel};
               default:      bus_d.hrdata = 32'h00000000;
            endcase
         end
         default:
         begin
            if (accept)
            begin
               bus_d.addr      = {haddr[7:2], 2'b00};
               bus_d.ah        = hwrite ? BRC_AH_WRITE : BRC_AH_RDWAIT;
               bus_d.hreadyout = hwrite;
            end
            else
            begin
               bus_d.ah = BRC_AH_IDLE;
            end
         end
      endcase
   end

   // bus registers cleared by system reset
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         bus_q           <= '0;
         bus_q.hreadyout <= 1'b1;
      end
      else
      begin
         bus_q <= bus_d;
      end
   end

   // ****************************************************************
   // Outputs, straight from flip-flops; hresp is tied to OKAY.
   // ****************************************************************
   assign hreadyout  = bus_q.hreadyout;
   assign hresp      = 1'b0;
   assign hrdata     = bus_q.hrdata;
   assign second_irq = bus_q.second_irq;
   assign alarm_irq  = bus_q.alarm_irq;
   assign wrap_irq   = bus_q.wrap_irq;
   assign alarm_out  = bus_q.alarm_out;

   // ****************************************************************
   // Checks.
   // ****************************************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn || !bkp_resetn);

   a_tick_reload: assert property (tick && !commit_go |=> core_q.div == $past(core_q.prl))
      else $error("divider not reloaded on tick");
   a_count_step: assert property ((tick && !commit_go) |=>
      core_q.cnt == $past(core_q.cnt) + 32'h00000001)
      else $error("counter did not advance on tick");
   a_second_flag: assert property (sec_ev |=> bus_q.second_tick_flag && second_irq == bus_q.ie[0])
      else $error("second flag or interrupt missing");
   a_wrap_zero: assert property ((wrap_ev && !commit_go) |=> bus_q.wrap_flag && core_q.cnt == 32'h0)
      else $error("overflow flag not tied to wrap");
   a_alarm_pin: assert property ((alarm_ev && !commit_go) |=>
      alarm_out && bus_q.alarm_hit_flag && core_q.cnt == $past(core_q.alr) + 32'h00000001)
      else $error("alarm output not tied to match");
   a_cfg_guard: assert property ((bus_q.ah == BRC_AH_WRITE && !bus_q.config_mode_bit && write_done_status) |=>
      bus_q.pend == $past(bus_q.pend))
      else $error("load buffered outside configuration mode");
   a_commit_len: assert property (commit_go |-> !write_done_status ##1 (write_done_status && bus_q.pend == 6'h00))
      else $error("commit did not finish cleanly");
   a_busy_ignore: assert property ((bus_q.ah == BRC_AH_WRITE && !write_done_status &&
      bus_q.addr == BRC_CRH_OFF) |=> bus_q.ie == $past(bus_q.ie))
      else $error("write taken while busy");
   a_read_wait: assert property ((accept && !hwrite && hreadyout) |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_sync_flag: assert property (rtc_rise |=> bus_q.regs_synced_flag)
      else $error("sync flag not set on RTC edge");

   c_tick: cover property (tick);
   c_commit: cover property (commit_go);
   c_alarm: cover property (alarm_ev);
   c_wrap: cover property (wrap_ev);

endmodule : brc_top

/* File: testbench/brc_ahb_master.sv */
// Purpose: AHB-Lite master standing in for the processor software.
// Assumes: One slave, whose hreadyout is the bus hready.
// Notes:   Single word transfers; every change follows a rising edge.
`timescale 1ns/10ps
module brc_ahb_master (
   // Bus.
   input  wire logic        hclk,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata
);
   initial
   begin
      {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
   end
   // One transfer; each phase is held until hready is seen high at an edge.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge hclk);
      hsel   <= 1'h1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize  <= 3'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask : xfer
endmodule : brc_ahb_master

/* File: testbench/backup_domain_rtc_core_bench.sv */
// Purpose: Self-checking bench of the RTC core.
// Assumes: Local source selected; it runs at one eighth of hclk.
// Notes:   Reset values first, then configuration, events and resets.
`timescale 1ns/10ps
module backup_domain_rtc_core_bench;
   import brc_pkg::*;
   logic hclk, hresetn, bkp_resetn, hsel, hwrite, hreadyout, hresp, run;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans;
   logic [2:0]  hsize, div_cnt = 3'h0;
   logic core_logic_local_clock, backup_write_unlock;
   logic second_irq, alarm_irq, wrap_irq, alarm_out;
   int   error_cnt = 0, checked = 0;
   localparam logic [7:0]  RA [6] = '{8'h00, 8'h04, 8'h14, 8'h0C, 8'h28, 8'h2C};
   localparam logic [31:0] RV [6] = '{32'h0, 32'h20, 32'h0, 32'h0, 32'h0, 32'h0};
   localparam logic [7:0]  CA [6] = '{8'h08, 8'h0C, 8'h18, 8'h1C, 8'h20, 8'h24};
   localparam logic [31:0] CV [6] = '{32'h0, 32'h3, 32'hFFFF, 32'hFFFE, 32'hFFFF, 32'hFFFF};
   // The source clock stands still until the bench lets it run.
   assign core_logic_local_clock = run & div_cnt[2];
   always @(posedge hclk) div_cnt <= div_cnt + 3'h1;
   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   brc_ahb_master brc_ahb_master_inst (.hclk, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hrdata);
   brc_top brc_top_inst (.hclk, .hresetn, .bkp_resetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .core_logic_local_clock, .external_low_speed_osc(1'b0),
      .internal_low_speed_osc(1'b0), .backup_write_unlock, .second_irq, .alarm_irq,
      .wrap_irq, .alarm_out);
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      brc_ahb_master_inst.xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      brc_ahb_master_inst.xfer(1'b0, a, 32'h0, q);
   endtask : rd
   // Polls the flag register until the given bit reads 1, within a bound.
   task automatic poll(input int b);
      q = 32'h0;
      for (int i = 0; i < 40 && q[b] !== 1'b1; i++) rd(8'h04);
   endtask : poll
   task automatic summarize;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize
   initial
   begin
      #200000;
      error_cnt++;
      summarize;
   end
   initial
   begin
      {hresetn, bkp_resetn, backup_write_unlock, run} = 4'h0;
      repeat (12) @(posedge hclk);
      hresetn    <= 1'b1;
      bkp_resetn <= 1'b1;
      foreach (RA[i])
      begin
         rd(RA[i]);
         chk("reset value", RV[i], q);
      end
      chk("okay response", 32'h0, {31'h0, hresp});
      wr(8'h04, 32'h10);
      rd(8'h04);
      chk("locked cnf", 32'h20, q);
      backup_write_unlock <= 1'b1;
      run <= 1'b1;
      wr(8'h04, 32'h10);
      foreach (CA[i]) wr(CA[i], CV[i]);
      wr(8'h04, 32'h0);
      rd(8'h04);
      chk("commit busy", 32'h0, q & 32'h20);
      poll(5);
      chk("commit done", 32'h20, q & 32'h20);
      wr(8'h00, 32'h7);
      for (int i = 0; i < 400 && wrap_irq !== 1'b1; i++) @(posedge hclk);
      chk("events", 32'hF, {28'h0, alarm_out, wrap_irq, alarm_irq, second_irq});
      rd(8'h18);
      chk("counter high", 32'h0, q);
      wr(8'h04, 32'h0);
      @(posedge hclk);
      chk("wrap cleared", 32'h0, {31'h0, wrap_irq});
      // The counter write outside configuration mode is attempted right after a second flag.
      poll(0);
      chk("second flag", 32'h1, q & 32'h1);
      wr(8'h18, 32'h1234);
      poll(3);
      rd(8'h18);
      chk("no cnf write", 32'h0, q);
      // With no source selected the core must stand still.
      wr(8'h28, 32'h3);
      rd(8'h28);
      chk("source select", 32'h3, q);
      wr(8'h04, 32'h0);
      repeat (40) @(posedge hclk);
      rd(8'h04);
      chk("stopped source", 32'h0, q & 32'h8);
      wr(8'h28, 32'h0);
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      rd(8'h00);
      chk("enables reset", 32'h0, q);
      wr(8'h04, 32'h0);
      poll(3);
      chk("synced", 32'h8, q & 32'h8);
      rd(8'h20);
      chk("alarm kept", 32'hFFFF, q);
      summarize;
   end
endmodule : backup_domain_rtc_core_bench
